// ===== adp_top.sv
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// per-axis drive power, enable and direction block with Wishbone slave
module adp_top
	import adp_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// motion profile phase per axis, from the profile generator
	input wire logic [2*NUM_AXES-1:0] phase_i,
	// move requests per axis, pulse
	input wire logic [NUM_AXES-1:0] move_req_i,
	// closed-loop calibration done per axis, pulse
	input wire logic [NUM_AXES-1:0] cal_done_i,
	// physical limit switch pins
	input wire adp_sw_t [NUM_AXES-1:0] sw_pin_i,
	// power stage drive
	output logic [7*NUM_AXES-1:0] cur_pct_o,
	output logic [NUM_AXES-1:0] stage_on_o,
	// motion gating and direction
	output logic [NUM_AXES-1:0] move_go_o,
	output logic [NUM_AXES-1:0] dir_rev_o,
	output logic [NUM_AXES-1:0] closed_loop_o,
	// remapped logical switches
	output logic [NUM_AXES-1:0] ref_switch_o,
	output logic [NUM_AXES-1:0] far_limit_switch_o
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	adp_axis_cfg_t [NUM_AXES-1:0] cfg_reg;
	adp_axis_cfg_t [NUM_AXES-1:0] cfg_next;
	logic [NUM_AXES-1:0] cl_reg;
	logic [NUM_AXES-1:0] cl_next;
	logic [NUM_AXES-1:0] go_reg;
	logic [NUM_AXES-1:0] go_next;
	logic ack_reg;
	logic ack_next;
	logic err_reg;
	logic err_next;
	logic [31:0] rd_reg;
	logic [31:0] rd_next;
	logic [7*NUM_AXES-1:0] pct_reg;
	logic [7*NUM_AXES-1:0] pct_comb;
	logic [NUM_AXES-1:0] son_reg;
	logic [NUM_AXES-1:0] son_comb;
	logic [NUM_AXES-1:0] rsw_reg;
	logic [NUM_AXES-1:0] fsw_reg;
	logic [NUM_AXES-1:0] rsw_next;
	logic [NUM_AXES-1:0] fsw_next;
	adp_sw_t [NUM_AXES-1:0] sw_sync;
	logic [2*NUM_AXES-1:0] sw_flat;
	// bus decode
	logic req;
	logic [1:0] ax;
	logic [7:0] blk;
	assign req = cyc_i && stb_i && !ack_reg && !err_reg;
	assign ax = adr_i[ADR_AXIS_LSB +: 2];
	assign blk = adr_i & ADR_BLOCK_MASK;
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	adp_sync #(
		.W(2*NUM_AXES)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(sw_pin_i),
		.q_o(sw_flat)
	);
	assign sw_sync = sw_flat;
	// ---------------------------------------------------------------
	// per-axis current units
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g++)
		begin : g_ax
			adp_current u_cur (
				.cfg_i(cfg_reg[g]),
				.phase_i(adp_phase_t'(phase_i[2*g +: 2])),
				.pct_o(pct_comb[7*g +: 7]),
				.stage_on_o(son_comb[g])
			);
		end
	endgenerate
	// ---------------------------------------------------------------
	// settings, bus access, closed loop
	// ---------------------------------------------------------------
	always_comb
	begin
		cfg_next = cfg_reg;
		cl_next = cl_reg;
		ack_next = 1'b0;
		err_next = 1'b0;
		rd_next = rd_reg;
		cl_next = cl_reg | cal_done_i;
		if (req)
		begin
			ack_next = 1'b1;
			rd_next = 32'h0000_0000;
			if (blk == ADR_LEVEL0 || blk == ADR_EN0 || blk == ADR_DIR0)
			begin
				if (we_i && sel_i[0])
				begin
					if (blk == ADR_LEVEL0)
					begin
						if (dat_i[6:0] <= LEVEL_MAX && dat_i[7] == 1'b0)
						begin
							cfg_next[ax].level = dat_i[6:0];
						end
					end
					else if (blk == ADR_EN0)
					begin
						if (dat_i[1:0] != EN_RSVD)
						begin
							cfg_next[ax].en = dat_i[1:0];
						end
					end
					else
					begin
						cfg_next[ax].dir = dat_i[0];
					end
				end
				if (blk == ADR_LEVEL0)
				begin
					rd_next = {25'h0, cfg_reg[ax].level};
				end
				else if (blk == ADR_EN0)
				begin
					// enable read sign-extended: -1 reads all ones
					rd_next = {{30{cfg_reg[ax].en[1]}}, cfg_reg[ax].en};
				end
				else
				begin
					rd_next = {31'h0, cfg_reg[ax].dir};
				end
			end
			else if (adr_i == ADR_LEVEL_ALL)
			begin
				for (int i = 0; i < NUM_AXES; i++)
				begin
					// value list for all axes, per byte lane
					if (we_i && sel_i[i] && dat_i[LEVEL_FW*i+7] == 1'b0
						&& dat_i[LEVEL_FW*i +: 7] <= LEVEL_MAX)
					begin
						cfg_next[i].level = dat_i[LEVEL_FW*i +: 7];
					end
					rd_next[LEVEL_FW*i +: 7] = cfg_reg[i].level;
				end
			end
			else if (adr_i == ADR_EN_ALL)
			begin
				for (int i = 0; i < NUM_AXES; i++)
				begin
					if (we_i && sel_i[0] && dat_i[EN_FW*i +: 2] != EN_RSVD)
					begin
						cfg_next[i].en = dat_i[EN_FW*i +: 2];
					end
					rd_next[EN_FW*i +: 2] = cfg_reg[i].en;
				end
			end
			else if (adr_i == ADR_DIR_ALL)
			begin
				for (int i = 0; i < NUM_AXES; i++)
				begin
					if (we_i && sel_i[0])
					begin
						cfg_next[i].dir = dat_i[i];
					end
					rd_next[i] = cfg_reg[i].dir;
				end
			end
			else if (adr_i == ADR_STATUS)
			begin
				// closed loop in bits 3:0, stage on 7:4, raw switches 15:8
				// raw readout from physical inputs, not remapped
				rd_next = {16'h0, sw_flat, son_reg, cl_reg};
			end
			else if (adr_i == ADR_CAL)
			begin
				// software calibration trigger re-enables closed loop
				if (we_i && sel_i[0])
				begin
					cl_next = cl_next | dat_i[NUM_AXES-1:0];
				end
			end
			else
			begin
				// unmapped: error instead of ack
				ack_next = 1'b0;
				err_next = 1'b1;
			end
		end
		// direction change drops closed loop, wins over calibration
		for (int i = 0; i < NUM_AXES; i++)
		begin
			if (cfg_next[i].dir != cfg_reg[i].dir)
			begin
				cl_next[i] = 1'b0;
			end
		end
	end
	// ---------------------------------------------------------------
	// motion gating and switch remap
	// ---------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NUM_AXES; i++)
		begin
			// disabled or off axis blocks motion
			go_next[i] = move_req_i[i] && (cfg_reg[i].en == EN_ON);
			// reversed direction swaps the two limit switches
			if (cfg_reg[i].dir == DIR_NORMAL)
			begin
				rsw_next[i] = sw_sync[i].end_input_low;
				fsw_next[i] = sw_sync[i].end_input_high;
			end
			else
			begin
				rsw_next[i] = sw_sync[i].end_input_high;
				fsw_next[i] = sw_sync[i].end_input_low;
			end
		end
	end
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_AXES; i++)
			begin
				cfg_reg[i].level <= LEVEL_RST;
				cfg_reg[i].en <= EN_ON;
				cfg_reg[i].dir <= DIR_NORMAL;
			end
			cl_reg <= '1;
			go_reg <= '0;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
			pct_reg <= '0;
			son_reg <= '0;
			rsw_reg <= '0;
			fsw_reg <= '0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			cl_reg <= cl_next;
			go_reg <= go_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			rd_reg <= rd_next;
			pct_reg <= pct_comb;
			son_reg <= son_comb;
			rsw_reg <= rsw_next;
			fsw_reg <= fsw_next;
		end
	end
	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign dat_o = rd_reg;
	assign ack_o = ack_reg;
	assign err_o = err_reg;
	assign cur_pct_o = pct_reg;
	assign stage_on_o = son_reg;
	assign move_go_o = go_reg;
	assign closed_loop_o = cl_reg;
	assign ref_switch_o = rsw_reg;
	assign far_limit_switch_o = fsw_reg;
	always_comb
	begin
		for (int i = 0; i < NUM_AXES; i++)
		begin
			dir_rev_o[i] = cfg_reg[i].dir;
		end
	end
endmodule
`default_nettype wire

// ===== adp_pkg.sv
package adp_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int unsigned NUM_AXES = 4;
	localparam logic [6:0] LEVEL_MAX = 7'h46;
	localparam logic [6:0] LEVEL_RST = 7'h00;
	localparam logic [6:0] PCT_FULL = 7'h64;
	// enable state codes, two's complement of -1, 0, 1
	localparam logic [1:0] EN_ON = 2'h1;
	localparam logic [1:0] EN_HOLD = 2'h0;
	localparam logic [1:0] EN_OFF = 2'h3;
	// code two has no meaning and is refused on write
	localparam logic [1:0] EN_RSVD = 2'h2;
	localparam logic [6:0] PCT_OFF = 7'h00;
	localparam logic DIR_NORMAL = 1'h0;
	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_LEVEL0 = 8'h00;
	localparam logic [7:0] ADR_EN0 = 8'h10;
	localparam logic [7:0] ADR_DIR0 = 8'h20;
	localparam logic [7:0] ADR_LEVEL_ALL = 8'h30;
	localparam logic [7:0] ADR_EN_ALL = 8'h34;
	localparam logic [7:0] ADR_DIR_ALL = 8'h38;
	localparam logic [7:0] ADR_STATUS = 8'h3C;
	localparam logic [7:0] ADR_CAL = 8'h40;
	localparam logic [7:0] ADR_BLOCK_MASK = 8'hF0;
	localparam logic [7:0] ADR_AXIS_MASK = 8'h0C;
	localparam int unsigned ADR_AXIS_LSB = 2;
	// all-axis field layouts: level 8 bits per axis, enable 2, direction 1
	localparam int unsigned LEVEL_FW = 8;
	localparam int unsigned EN_FW = 2;
	// motion profile phases per axis
	typedef enum logic [1:0] {
		ADP_IDLE = 2'h0,
		ADP_ACCEL = 2'h1,
		ADP_CRUISE = 2'h3,
		ADP_DECEL = 2'h2
	} adp_phase_t;
	// per-axis setting bundle
	typedef struct packed {
		logic [6:0] level;
		logic [1:0] en;
		logic dir;
	} adp_axis_cfg_t;
	// per-axis physical limit inputs
	typedef struct packed {
		logic end_input_low;
		logic end_input_high;
	} adp_sw_t;
endpackage

// ===== adp_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser; first flop feeds only the second
module adp_sync
	import adp_pkg::*;
#(
	parameter int unsigned W = 1
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	// ---------------------------------------------------------------
	// two stages
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
		end
		else
		begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
		end
	end
	assign q_o = s2_reg;
endmodule
`default_nettype wire

// ===== adp_current.sv
`timescale 1ns/100ps
`default_nettype none
// per-axis current percentage from settings and motion phase
module adp_current
	import adp_pkg::*;
(
	// settings
	input wire adp_axis_cfg_t cfg_i,
	input wire adp_phase_t phase_i,
	// current command in percent
	output logic [6:0] pct_o,
	output logic stage_on_o
);
	// ---------------------------------------------------------------
	// current selection
	// ---------------------------------------------------------------
	always_comb
	begin
		stage_on_o = (cfg_i.en != EN_OFF);
		pct_o = PCT_FULL;
		// decel and short moves keep full current
		if (phase_i == ADP_CRUISE)
		begin
			pct_o = PCT_FULL - cfg_i.level;
		end
		if (!stage_on_o)
		begin
			pct_o = PCT_OFF;
		end
	end
endmodule
`default_nettype wire

// ===== adp_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// axis 0 drive checker
// ---------------------------------------------------------------
module adp_assertions
	import adp_pkg::*;
(
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic err_o,
	// axis side
	input wire logic [2*NUM_AXES-1:0] phase_i,
	input wire logic [NUM_AXES-1:0] move_req_i,
	input wire adp_sw_t [NUM_AXES-1:0] sw_pin_i,
	input wire logic [7*NUM_AXES-1:0] cur_pct_o,
	input wire logic [NUM_AXES-1:0] stage_on_o,
	input wire logic [NUM_AXES-1:0] move_go_o,
	input wire logic [NUM_AXES-1:0] dir_rev_o,
	input wire logic [NUM_AXES-1:0] closed_loop_o,
	input wire logic [NUM_AXES-1:0] ref_switch_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [6:0] pct0;
	// axis 0 current field
	assign pct0 = cur_pct_o[6:0];
	a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_idle_full: assert property (phase_i[1:0] != ADP_CRUISE |=> !stage_on_o[0] || pct0 == PCT_FULL)
		else $error("current reduced outside cruise");
	a_cruise_floor: assert property (phase_i[1:0] == ADP_CRUISE |=> !stage_on_o[0] ||
		(pct0 >= PCT_FULL - LEVEL_MAX && pct0 <= PCT_FULL)) else $error("cruise current out of range");
	a_off_zero: assert property (!stage_on_o[0] |-> pct0 == 7'h00)
		else $error("current while stage off");
	a_go_gate: assert property (move_go_o[0] |-> $past(move_req_i[0]) && stage_on_o[0])
		else $error("move started without request");
	a_dir_loop: assert property ($changed(dir_rev_o[0]) |-> !closed_loop_o[0])
		else $error("closed loop kept over direction change");
	// the three-stage pin path is only trusted once reset is three edges old
	a_sw_remap: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
		&& $stable(dir_rev_o[0]) |-> ref_switch_o[0] == (dir_rev_o[0] ?
		$past(sw_pin_i[0].end_input_high, 3) : $past(sw_pin_i[0].end_input_low, 3)))
		else $error("limit switch mapping wrong");
	c_cruise: cover property (phase_i[1:0] == ADP_CRUISE);
	c_error: cover property (err_o);
	c_reverse: cover property ($rose(dir_rev_o[0]));
endmodule
bind adp_top adp_assertions u_adp_assertions (.*);
`default_nettype wire

// ===== adp_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// profile generator standing behind the power stages
// ---------------------------------------------------------------
module adp_stage_model
	import adp_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// move start and short-move choice
	input wire logic [NUM_AXES-1:0] go_i,
	input wire logic [NUM_AXES-1:0] short_i,
	// profile phase per axis
	output logic [2*NUM_AXES-1:0] phase_o
);
	logic [3:0] t [NUM_AXES];
	logic [NUM_AXES-1:0] sh;
	// step count: 1-3 accel, 4-9 cruise, 10-12 decel, 0 idle
	always @(posedge clk_i)
	begin
		for (int a = 0; a < NUM_AXES; a++)
		begin
			if (rst_i)
				t[a] <= 4'h0;
			else if (go_i[a])
			begin
				t[a] <= 4'h1;
				sh[a] <= short_i[a];
			end
			else if (t[a] == 4'h3 && sh[a])
				t[a] <= 4'hA;
			else if (t[a] != 4'h0)
				t[a] <= (t[a] == 4'hC) ? 4'h0 : t[a] + 4'h1;
		end
	end
	always_comb
		for (int a = 0; a < NUM_AXES; a++)
			phase_o[2*a +: 2] = (t[a] == 4'h0) ? ADP_IDLE : (t[a] < 4'h4) ? ADP_ACCEL :
				(t[a] < 4'hA) ? ADP_CRUISE : ADP_DECEL;
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// drive block bench
// ---------------------------------------------------------------
module testbench
	import adp_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, err_o;
	logic [7:0] adr_i = 8'h00, phase_i;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic [3:0] sel_i = 4'hF, move_req_i = 4'h0, cal_done_i = 4'h0, short_i = 4'h0;
	logic [3:0] stage_on_o, move_go_o, dir_rev_o, closed_loop_o, ref_switch_o, far_limit_switch_o;
	adp_sw_t [NUM_AXES-1:0] sw_pin_i = '0;
	logic [27:0] cur_pct_o;
	logic [32:0] exp_q [$];
	logic [32:0] x;
	logic [6:0] lv [4];
	int num_errors = 0, total_checks = 0, cycles = 0;
	// free-running 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	adp_top u_adp_top (.*);
	adp_stage_model u_adp_stage_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(move_go_o),
		.short_i(short_i), .phase_o(phase_i));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// classic cycle: hold until answered, then idle one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && err_o !== 1'b1)
			@(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] d);
		exp_q.push_back({e, d});
		wb(1'b0, a, 32'h0);
	endtask
	task automatic move(input logic s);
		short_i <= {3'h0, s};
		move_req_i <= 4'h1;
		@(posedge clk_i);
		move_req_i <= 4'h0;
	endtask
	// read answers are matched against the oldest note
	always @(posedge clk_i)
		if ((ack_o === 1'b1 || err_o === 1'b1) && we_i === 1'b0)
		begin
			x = exp_q.pop_front();
			chk(32'(err_o), 32'(x[32])); // answer kind
			if (!x[32])
				chk(dat_o, x[31:0]); // read value
		end
	// hang guard
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	initial
	begin
		void'($urandom(10));
		sw_pin_i <= 8'($urandom);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADR_LEVEL_ALL, 1'b0, 32'h0);
		rd(ADR_EN_ALL, 1'b0, 32'h55);
		rd(ADR_DIR_ALL, 1'b0, 32'h0);
		// random levels, axis 0 then pinned to the top value
		for (int a = 0; a < 4; a++)
		begin
			lv[a] = (a == 0) ? LEVEL_MAX : 7'($urandom % 71);
			wb(1'b1, ADR_LEVEL0 + 8'(4 * a), {25'h0, lv[a]});
			rd(ADR_LEVEL0 + 8'(4 * a), 1'b0, {25'h0, lv[a]});
		end
		wb(1'b1, ADR_LEVEL0, 32'h47);
		rd(ADR_LEVEL0, 1'b0, {25'h0, lv[0]});
		rd(ADR_LEVEL_ALL, 1'b0, {1'b0, lv[3], 1'b0, lv[2], 1'b0, lv[1], 1'b0, lv[0]});
		// long move, then a short one that never cruises
		move(1'b0);
		while (phase_i[1:0] != ADP_CRUISE)
			@(posedge clk_i);
		repeat (3) @(posedge clk_i);
		chk(32'(cur_pct_o[6:0]), 32'(PCT_FULL - lv[0]));
		while (phase_i[1:0] != ADP_DECEL)
			@(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chk(32'(cur_pct_o[6:0]), 32'(PCT_FULL));
		move(1'b1);
		repeat (16)
		begin
			@(posedge clk_i);
			chk(32'(cur_pct_o[6:0]), 32'(PCT_FULL));
		end
		// held axis: powered but blocked
		wb(1'b1, ADR_EN0, 32'h0);
		rd(ADR_EN0, 1'b0, 32'h0);
		move(1'b0);
		@(posedge clk_i);
		chk(32'(move_go_o[0]), 32'h0);
		chk(32'(stage_on_o[0]), 32'h1);
		// stage off, then a reserved code that must not stick
		wb(1'b1, ADR_EN0, 32'h3);
		wb(1'b1, ADR_EN0, 32'h2);
		rd(ADR_EN0, 1'b0, 32'hFFFFFFFF);
		chk(32'(stage_on_o[0]), 32'h0);
		chk(32'(cur_pct_o[6:0]), 32'h0);
		wb(1'b1, ADR_EN_ALL, 32'h55);
		// one-time direction setup, then recalibration
		// reversal swaps the two limit switches and drops closed loop until calibration is done
		wb(1'b1, ADR_DIR0, 32'h1);
		repeat (4) @(posedge clk_i);
		chk(32'(dir_rev_o), 32'h1);
		chk(32'(ref_switch_o[0]), 32'(sw_pin_i[0].end_input_high));
		chk(32'(far_limit_switch_o[0]), 32'(sw_pin_i[0].end_input_low));
		chk(32'(closed_loop_o[0]), 32'h0);
		rd(ADR_STATUS, 1'b0, {16'h0, sw_pin_i, 8'hFE});
		rd(ADR_DIR_ALL, 1'b0, 32'h1);
		cal_done_i <= 4'h1;
		@(posedge clk_i);
		cal_done_i <= 4'h0;
		repeat (2) @(posedge clk_i);
		chk(32'(closed_loop_o[0]), 32'h1);
		rd(8'h80, 1'b1, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(32'(exp_q.size()), 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
